// file: rtl/ibd_baud_counter.sv
// Sixteen-bit reloading down counter that paces the serial bit timing.
// Assumes the reload value is steady while the counter runs.
`timescale 1ns/10ps
module ibd_baud_counter #(
    parameter int W = 16
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic         i_run,
    input  wire logic [W-1:0] i_reload,
    output logic      [W-1:0] o_count,
    output logic              o_tick
);

    logic [W-1:0] count_ff;
    logic         tick_ff;

    // Count down to one, then reload; a reload of zero gives 2^W cycles
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            count_ff <= '1;
            tick_ff  <= 1'b0;
        end else if (!i_run) begin
            count_ff <= i_reload;
            tick_ff  <= 1'b0;
        end else if (count_ff == W'(1)) begin
            count_ff <= i_reload;
            tick_ff  <= 1'b1;
        end else begin
            count_ff <= count_ff - W'(1);
            tick_ff  <= 1'b0;
        end
    end

    assign o_count = count_ff;
    assign o_tick  = tick_ff;

endmodule // ibd_baud_counter

// file: rtl/ibd_pkg.sv
// Shared constants and carriers of the two-wire baud and diagnostic slice.
// Assumes an APB master with 32-bit data and word-aligned registers.
package ibd_pkg;

    // APB address width
    localparam int IBD_ADDR_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_BAUD_HIGH = 12'hf53;
    localparam logic [11:0] IDX_BAUD_LOW  = 12'hf54;
    localparam logic [11:0] IDX_DIAGNOSTIC_ENABLE      = 12'hf55;
    localparam logic [11:0] IDX_CTRL      = 12'hf56;

    // Reset values
    localparam logic [7:0] BAUD_RESET = 8'hff;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Control register fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_DIAGNOSTIC_ENABLE_BIT  = 1;
    localparam int CTRL_TIMER_BIT = 2;
    localparam logic [7:0] CTRL_MASK = 8'h07;

    // Diagnostic state register fields
    localparam int DIAGNOSTIC_ENABLE_SCL_BIT  = 7;
    localparam int DIAGNOSTIC_ENABLE_SDA_BIT  = 6;
    localparam int DIAGNOSTIC_ENABLE_STOP_BIT = 5;

    // Transfer state codes as software sees them
    localparam logic [4:0] CODE_IDLE  = 5'h00;
    localparam logic [4:0] CODE_START = 5'h01;
    localparam logic [4:0] CODE_BIT7  = 5'h02;
    localparam logic [4:0] CODE_ACK   = 5'h0a;

    // Internal sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_ACK   = 4'b1000
    } ibd_state_t;

    // APB request from the master
    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [IBD_ADDR_W-1:0] paddr;
        logic [31:0]           pwdata;
        logic [3:0]            pstrb;
    } ibd_apb_req_t;

    // APB answer from this slave
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ibd_apb_rsp_t;

endpackage : ibd_pkg

// file: rtl/ibd_top.sv
// Baud reload registers, diagnostic state view and bit sequencer.
// Assumes an APB master on i_clk_sys and open-drain SCL/SDA pads outside.
`timescale 1ns/10ps
module ibd_top (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    input  wire ibd_pkg::ibd_apb_req_t i_apb,
    output ibd_pkg::ibd_apb_rsp_t      o_apb,
    input  wire logic                  i_scl_in,
    input  wire logic                  i_sda_in,
    input  wire logic                  i_xfer_go,
    input  wire logic [7:0]            i_xfer_byte,
    output logic                       o_scl_out,
    output logic                       o_scl_oe,
    output logic                       o_sda_out,
    output logic                       o_sda_oe,
    output logic [7:0]                 o_rx_byte,
    output logic                       o_xfer_done,
    output logic                       o_timer_tick
);

    // Registers
    logic [7:0]          baud_low_ff;
    logic [7:0]          baud_high_ff;
    logic [7:0]          ctrl_ff;
    ibd_pkg::ibd_apb_rsp_t rsp_ff;
    // Pin synchronisers
    logic [1:0]          scl_sync_ff;
    logic [1:0]          sda_sync_ff;
    // Sequencer
    ibd_pkg::ibd_state_t state_ff;
    ibd_pkg::ibd_state_t nxt_state;
    logic [2:0]          bit_idx_ff;
    logic [2:0]          nxt_bit_idx;
    logic                phase_ff;
    logic [7:0]          tx_byte_ff;
    logic [7:0]          rx_byte_ff;
    logic                done_ff;
    logic                stop_cnt_ff;
    logic                scl_oe_ff;
    logic                sda_oe_ff;
    logic                timer_tick_ff;
    // Decoded controls and counter
    logic                ctrl_en;
    logic                diagnostic_enable_en;
    logic                timer_en;
    logic [15:0]         baud_reload_value;
    logic [15:0]         baud_count;
    logic                baud_tick;
    logic                step;
    logic [4:0]          state_code;
    logic [7:0]          diagnostic_enable_word;
    // APB decode
    logic                setup_rd;
    logic                wr_take;
    logic [11:0]         word_idx;
    logic                addr_low_ok;
    logic                hit_low;
    logic                hit_high;
    logic                hit_diagnostic_enable;
    logic                hit_ctrl;
    logic                mapped;
    logic [7:0]          rd_byte;

    assign ctrl_en  = ctrl_ff[ibd_pkg::CTRL_EN_BIT];
    assign diagnostic_enable_en  = ctrl_ff[ibd_pkg::CTRL_DIAGNOSTIC_ENABLE_BIT];
    assign timer_en = ctrl_ff[ibd_pkg::CTRL_TIMER_BIT];

    // Both bytes feed the generator as one reload word
    assign baud_reload_value = {baud_high_ff, baud_low_ff};

    // Counter runs while the controller is enabled or while used as a timer
    ibd_baud_counter #(
        .W (16)
    ) u_baud (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_run     (ctrl_en | timer_en),
        .i_reload  (baud_reload_value),
        .o_count   (baud_count),
        .o_tick    (baud_tick)
    );

    // Two flops on the pads before anything looks at them
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], i_scl_in};
            sda_sync_ff <= {sda_sync_ff[0], i_sda_in};
        end
    end

    // Address decode; unused upper address bits must be zero
    assign word_idx    = i_apb.paddr[13:2];
    assign addr_low_ok = (i_apb.paddr[1:0] == 2'h0)
                         && (i_apb.paddr[15:14] == 2'h0);
    assign hit_low     = addr_low_ok && (word_idx == ibd_pkg::IDX_BAUD_LOW);
    assign hit_high    = addr_low_ok && (word_idx == ibd_pkg::IDX_BAUD_HIGH);
    assign hit_diagnostic_enable    = addr_low_ok && (word_idx == ibd_pkg::IDX_DIAGNOSTIC_ENABLE);
    assign hit_ctrl    = addr_low_ok && (word_idx == ibd_pkg::IDX_CTRL);
    assign mapped      = hit_low | hit_high | hit_diagnostic_enable | hit_ctrl;

    // Setup cycle samples the read; access edge with pready commits
    assign setup_rd = i_apb.psel && !i_apb.penable;
    assign wr_take  = i_apb.psel && i_apb.penable && rsp_ff.pready
                      && i_apb.pwrite && i_apb.pstrb[0];

    // Diagnostic view: pads, stop counter and state code
    always_comb begin
        diagnostic_enable_word = 8'h00;
        diagnostic_enable_word[ibd_pkg::DIAGNOSTIC_ENABLE_SCL_BIT]  = scl_sync_ff[1];
        diagnostic_enable_word[ibd_pkg::DIAGNOSTIC_ENABLE_SDA_BIT]  = sda_sync_ff[1];
        diagnostic_enable_word[ibd_pkg::DIAGNOSTIC_ENABLE_STOP_BIT] = stop_cnt_ff;
        diagnostic_enable_word[4:0]                    = state_code;
    end

    // Read mux; live counter replaces stored bytes in diagnostic mode
    always_comb begin
        rd_byte = 8'h00;
        if (hit_low) begin
            rd_byte = diagnostic_enable_en ? baud_count[7:0] : baud_low_ff;
        end else if (hit_high) begin
            rd_byte = diagnostic_enable_en ? baud_count[15:8] : baud_high_ff;
        end else if (hit_diagnostic_enable) begin
            rd_byte = diagnostic_enable_word;
        end else if (hit_ctrl) begin
            rd_byte = ctrl_ff & ibd_pkg::CTRL_MASK;
        end
    end

    // One wait-free access cycle: answer is registered at setup
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rsp_ff <= '0;
        end else if (setup_rd) begin
            rsp_ff.pready  <= 1'b1;
            rsp_ff.pslverr <= !mapped;
            rsp_ff.prdata  <= i_apb.pwrite ? 32'h0 : {24'h0, rd_byte};
        end else begin
            rsp_ff.pready  <= 1'b0;
            rsp_ff.pslverr <= 1'b0;
        end
    end

    // Stored reload bytes; a write to the state view hits nothing
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            baud_low_ff  <= ibd_pkg::BAUD_RESET;
            baud_high_ff <= ibd_pkg::BAUD_RESET;
        end else if (wr_take && hit_low) begin
            baud_low_ff  <= i_apb.pwdata[7:0];
        end else if (wr_take && hit_high) begin
            baud_high_ff <= i_apb.pwdata[7:0];
        end
    end

    // Control bits; undefined bits stay zero
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl_ff <= ibd_pkg::CTRL_RESET;
        end else if (wr_take && hit_ctrl) begin
            ctrl_ff <= i_apb.pwdata[7:0] & ibd_pkg::CTRL_MASK;
        end
    end

    // Timer tick only while the serial engine is off
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            timer_tick_ff <= 1'b0;
        end else begin
            timer_tick_ff <= baud_tick && timer_en && !ctrl_en;
        end
    end

    // Two counter ticks per bit: low half then high half
    assign step = baud_tick && phase_ff;

    // Encoded state for software; data bits count 7 down to 0
    always_comb begin
        case (state_ff)
            ibd_pkg::ST_IDLE:  state_code = ibd_pkg::CODE_IDLE;
            ibd_pkg::ST_START: state_code = ibd_pkg::CODE_START;
            ibd_pkg::ST_DATA:  state_code = ibd_pkg::CODE_BIT7
                                            + 5'(3'h7 - bit_idx_ff);
            ibd_pkg::ST_ACK:   state_code = ibd_pkg::CODE_ACK;
            default:           state_code = ibd_pkg::CODE_IDLE;
        endcase
    end

    // Next state of the bit sequencer
    always_comb begin
        nxt_state   = state_ff;
        nxt_bit_idx = bit_idx_ff;
        case (state_ff)
            ibd_pkg::ST_IDLE: begin
                if (ctrl_en && i_xfer_go) begin
                    nxt_state = ibd_pkg::ST_START;
                end
            end
            ibd_pkg::ST_START: begin
                if (step) begin
                    nxt_state   = ibd_pkg::ST_DATA;
                    nxt_bit_idx = 3'h7; // MSB goes out first
                end
            end
            ibd_pkg::ST_DATA: begin
                if (step && bit_idx_ff == 3'h0) begin
                    nxt_state = ibd_pkg::ST_ACK;
                end else if (step) begin
                    nxt_bit_idx = bit_idx_ff - 3'h1;
                end
            end
            ibd_pkg::ST_ACK: begin
                if (step) begin
                    nxt_state = ibd_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = ibd_pkg::ST_IDLE;
            end
        endcase
        // Clearing enable aborts any transfer at once
        if (!ctrl_en) begin
            nxt_state = ibd_pkg::ST_IDLE;
        end
    end

    // Sequencer state and half-bit phase
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff   <= ibd_pkg::ST_IDLE;
            bit_idx_ff <= 3'h7;
            phase_ff   <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            bit_idx_ff <= nxt_bit_idx;
            if (nxt_state == ibd_pkg::ST_IDLE
                || state_ff == ibd_pkg::ST_IDLE) begin
                phase_ff <= 1'b0;
            end else if (baud_tick) begin
                phase_ff <= !phase_ff;
            end
        end
    end

    // Byte capture: transmit byte at go, receive bits at each bit end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tx_byte_ff <= 8'h00;
            rx_byte_ff <= 8'h00;
        end else if (state_ff == ibd_pkg::ST_IDLE
                     && nxt_state == ibd_pkg::ST_START) begin
            tx_byte_ff <= i_xfer_byte;
        end else if (state_ff == ibd_pkg::ST_DATA && step) begin
            rx_byte_ff <= {rx_byte_ff[6:0], sda_sync_ff[1]};
        end
    end

    // Done pulse as the acknowledge bit closes; stop signal spans that bit
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            done_ff     <= 1'b0;
            stop_cnt_ff <= 1'b0;
        end else begin
            done_ff     <= (state_ff == ibd_pkg::ST_ACK) && step;
            stop_cnt_ff <= (nxt_state == ibd_pkg::ST_ACK);
        end
    end

    // Pad drive is open drain: enable pulls the line low
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            case (nxt_state)
                ibd_pkg::ST_START: begin
                    scl_oe_ff <= 1'b0;
                    sda_oe_ff <= 1'b1;
                end
                ibd_pkg::ST_DATA: begin
                    scl_oe_ff <= !phase_ff ^ baud_tick;
                    sda_oe_ff <= !tx_byte_ff[nxt_bit_idx];
                end
                ibd_pkg::ST_ACK: begin
                    scl_oe_ff <= !phase_ff ^ baud_tick;
                    sda_oe_ff <= 1'b0; // Partner drives the ack bit
                end
                default: begin
                    scl_oe_ff <= 1'b0;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    assign o_apb        = rsp_ff;
    assign o_scl_out    = 1'b0;
    assign o_sda_out    = 1'b0;
    assign o_scl_oe     = scl_oe_ff;
    assign o_sda_oe     = sda_oe_ff;
    assign o_rx_byte    = rx_byte_ff;
    assign o_xfer_done  = done_ff;
    assign o_timer_tick = timer_tick_ff;

    // Checks on the design's own outputs and state
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_low_reset_value: assert property (
        $fell(i_rst) |-> $past(baud_low_ff) == ibd_pkg::BAUD_RESET)
        else $error("low baud byte not ff after reset");
    a_low_write_store: assert property (
        wr_take && hit_low |=> baud_low_ff == $past(i_apb.pwdata[7:0]))
        else $error("low baud byte write lost");
    a_diagnostic_enable_read_live: assert property (
        setup_rd && !i_apb.pwrite && hit_low && diagnostic_enable_en
        |=> o_apb.prdata[7:0] == $past(baud_count[7:0]))
        else $error("diagnostic read of low byte not live count");
    a_stored_read_back: assert property (
        setup_rd && !i_apb.pwrite && hit_low && !diagnostic_enable_en
        |=> o_apb.prdata == {24'h0, $past(baud_low_ff)})
        else $error("low byte read not stored value");
    a_diagnostic_enable_write_none: assert property (
        wr_take && hit_diagnostic_enable
        |=> $stable(baud_low_ff) && $stable(ctrl_ff) && $stable(baud_high_ff))
        else $error("write to diagnostic state changed registers");
    a_diagnostic_enable_pads_shown: assert property (
        setup_rd && !i_apb.pwrite && hit_diagnostic_enable
        |=> o_apb.prdata[7:5] == {$past(scl_sync_ff[1]),
                                 $past(sda_sync_ff[1]), $past(stop_cnt_ff)})
        else $error("diagnostic pad or stop bits wrong");
    a_data_order_msb: assert property (
        state_ff == ibd_pkg::ST_START && step && ctrl_en
        |=> state_ff == ibd_pkg::ST_DATA && state_code == ibd_pkg::CODE_BIT7)
        else $error("data does not start at bit 7");
    a_ack_after_bit0: assert property (
        state_ff == ibd_pkg::ST_DATA && bit_idx_ff == 3'h0 && step && ctrl_en
        |=> state_code == ibd_pkg::CODE_ACK)
        else $error("acknowledge does not follow bit 0");
    a_idle_code_zero: assert property (
        state_ff == ibd_pkg::ST_IDLE |-> diagnostic_enable_word[4:0] == 5'h00)
        else $error("idle state code not zero");
    a_timer_tick_off: assert property (
        o_timer_tick |-> $past(timer_en) && !$past(ctrl_en))
        else $error("timer tick while controller enabled");

    c_timer_tick: cover property (o_timer_tick ##[1:300] o_timer_tick);
    c_xfer_done: cover property (o_xfer_done);
    c_diagnostic_enable_read: cover property (setup_rd && hit_diagnostic_enable && !i_apb.pwrite);
    c_unmapped: cover property (o_apb.pready && o_apb.pslverr);

endmodule // ibd_top

// file: testbench/ibd_partner.sv
// Two-wire bus partner: pulled-up clock and data lines shared with the pads.
// Assumes the controller's enables are high while it pulls a line.
`timescale 1ns/10ps
module ibd_partner (
    input  wire logic i_clk_sys,
    input  wire logic i_scl_out,
    input  wire logic i_scl_oe,
    input  wire logic i_sda_out,
    input  wire logic i_sda_oe,
    input  wire logic i_hold_scl,
    input  wire logic i_hold_sda,
    output logic      o_scl,
    output logic      o_sda
);
    logic hold_scl_ff = 1'b0;
    logic hold_sda_ff = 1'b0;

    // Holds land on a clock edge, like a real device's output stage
    always_ff @(posedge i_clk_sys) begin
        hold_scl_ff <= i_hold_scl;
        hold_sda_ff <= i_hold_sda;
    end

    // Wired-AND with pull-up; a released line reads high, not its last value
    assign o_scl = (i_scl_oe ? i_scl_out : 1'b1) & ~hold_scl_ff;
    assign o_sda = (i_sda_oe ? i_sda_out : 1'b1) & ~hold_sda_ff;
endmodule // ibd_partner

// file: testbench/ibd_top_tb.sv
// Directed bench for the baud and diagnostic slice over APB.
// Assumes the partner model in ibd_partner.sv holds the bus lines.
`timescale 1ns/10ps
module ibd_top_tb;
    localparam logic [15:0] A_HI = {2'b00, ibd_pkg::IDX_BAUD_HIGH, 2'b00};
    localparam logic [15:0] A_LO = {2'b00, ibd_pkg::IDX_BAUD_LOW, 2'b00};
    localparam logic [15:0] A_DG = {2'b00, ibd_pkg::IDX_DIAGNOSTIC_ENABLE, 2'b00};
    localparam logic [15:0] A_CT = {2'b00, ibd_pkg::IDX_CTRL, 2'b00};

    logic                  clk;
    logic                  rst;
    ibd_pkg::ibd_apb_req_t req;
    ibd_pkg::ibd_apb_rsp_t rsp;
    logic                  scl;
    logic                  sda;
    logic                  scl_out;
    logic                  scl_oe;
    logic                  sda_out;
    logic                  sda_oe;
    logic                  hold_scl;
    logic                  hold_sda;
    logic                  go;
    logic [7:0]            xbyte;
    logic [7:0]            rx;
    logic                  done;
    logic                  tick;
    int                    bad_count = 0;
    int                    checks = 0;
    int                    done_n = 0;
    int                    scl_n = 0;

    ibd_top ibd_top_inst (
        .i_clk_sys    (clk),
        .i_rst        (rst),
        .i_apb        (req),
        .o_apb        (rsp),
        .i_scl_in     (scl),
        .i_sda_in     (sda),
        .i_xfer_go    (go),
        .i_xfer_byte  (xbyte),
        .o_scl_out    (scl_out),
        .o_scl_oe     (scl_oe),
        .o_sda_out    (sda_out),
        .o_sda_oe     (sda_oe),
        .o_rx_byte    (rx),
        .o_xfer_done  (done),
        .o_timer_tick (tick)
    );

    ibd_partner ibd_partner_inst (
        .i_clk_sys  (clk),
        .i_scl_out  (scl_out),
        .i_scl_oe   (scl_oe),
        .i_sda_out  (sda_out),
        .i_sda_oe   (sda_oe),
        .i_hold_scl (hold_scl),
        .i_hold_sda (hold_sda),
        .o_scl      (scl),
        .o_sda      (sda)
    );

    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Done pulses counted apart, so a double pulse is not missed
    always @(posedge clk) begin
        if (done === 1'b1) done_n <= done_n + 1;
        if (scl_oe === 1'b1) scl_n <= scl_n + 1;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= {24'h000000, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        // Slave answers at the first access edge; the watchdog ends a hang
        chk(n, 32'd1, "pready latency");
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] wd);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, wd, rd, er);
        chk({31'h0, er}, 32'h0, "write error");
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [31:0] rd);
        logic er;
        apb(1'b0, a, 8'h00, rd, er);
        chk({31'h0, er}, 32'h0, "read error");
    endtask

    // Cycles from now to the edge that sees the next timer tick
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 2000);
    endtask

    task automatic pulse_go(input logic [7:0] b);
        @(posedge clk);
        go    <= 1'b1;
        xbyte <= b;
        @(posedge clk);
        go    <= 1'b0;
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] d2;
        logic        e;
        logic [4:0]  last;
        logic [4:0]  got[$];
        int          i;
        rst      = 1'b1;
        req      = {3'b000, 16'h0000, 32'h00000000, 4'h1};
        hold_scl = 1'b0;
        hold_sda = 1'b0;
        go       = 1'b0;
        xbyte    = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(A_LO, d);
        chk(d, 32'h000000ff, "low reset");
        chk({28'h0, scl_out, scl_oe, sda_out, sda_oe}, 32'h0, "pads free");
        rd_reg(A_DG, d);
        chk(d, 32'h000000c0, "diagnostic_enable idle");
        wr_reg(A_LO, 8'h5a);
        rd_reg(A_LO, d);
        chk(d, 32'h0000005a, "low stored");
        // Writes to the diagnostic view must leave everything alone
        wr_reg(A_DG, 8'h3f);
        rd_reg(A_DG, d);
        chk(d, 32'h000000c0, "diagnostic_enable write");
        rd_reg(A_LO, d);
        chk(d, 32'h0000005a, "low kept");
        // A write with its byte strobe off must not land
        req.pstrb <= 4'h0;
        wr_reg(A_LO, 8'h11);
        req.pstrb <= 4'h1;
        rd_reg(A_LO, d);
        chk(d, 32'h0000005a, "strobe off");
        apb(1'b0, 16'h0000, 8'h00, d, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(d, 32'h0, "unmapped data");
        // Pad levels through the synchronisers; wait covers two flops
        hold_sda <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(A_DG, d);
        chk(d & 32'hc0, 32'h80, "data line low");
        hold_sda <= 1'b0;
        hold_scl <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(A_DG, d);
        chk(d & 32'hc0, 32'h40, "clock line low");
        hold_scl <= 1'b0;
        // Timer mode uses both bytes as one reload value
        wr_reg(A_HI, 8'h01);
        wr_reg(A_LO, 8'h04);
        wr_reg(A_CT, 8'h04);
        wait_tick(i);
        wait_tick(i);
        chk(i, 32'd260, "timer interval");
        // Live count: reads are three cycles apart; skip near the wrap
        wr_reg(A_CT, 8'h06);
        rd_reg(A_LO, d);
        rd_reg(A_LO, d2);
        if (d[7:0] > 8'h03) chk(d2, d - 32'd3, "live count");
        wr_reg(A_CT, 8'h04);
        rd_reg(A_LO, d);
        chk(d, 32'h00000004, "stored again");
        // A start request while disabled must be ignored
        wr_reg(A_CT, 8'h00);
        wr_reg(A_HI, 8'h00);
        pulse_go(8'ha5);
        rd_reg(A_DG, d);
        chk(d & 32'h1f, 32'h0, "go ignored");
        // Byte transfer, polled fast enough to see every state
        wr_reg(A_CT, 8'h01);
        pulse_go(8'ha5);
        last = 5'h00;
        for (i = 0; i < 80 && !(got.size() > 0 && last == 5'h00); i++) begin
            rd_reg(A_DG, d);
            chk(d[5], d[4:0] == ibd_pkg::CODE_ACK, "stop flag");
            if (d[4:0] !== last) got.push_back(d[4:0]);
            last = d[4:0];
        end
        chk(got.size(), 32'd11, "code count");
        for (i = 0; i < got.size() && i < 11; i++) begin
            chk(got[i], (i == 10) ? 0 : i + 1, "code order");
        end
        chk(done_n, 32'd1, "done pulses");
        chk({31'h0, scl_n > 0}, 32'h1, "clock line pulled");
        chk(rx, 32'h000000a5, "rx byte");
        finish_test();
    end

    // Watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule // ibd_top_tb
